// ===== inc/flash_guard_defs.vh
// Purpose: constants for the flash section write guard
// Assumes: word addresses, 17-bit wide
// Notes:   lock codes are 2 bits, 2'b11 means no lock
`ifndef FLASH_GUARD_DEFS_VH
`define FLASH_GUARD_DEFS_VH

`define ADDR_W          17
`define APP_END         17'h16fff
`define TBL_START       17'h17000
`define TBL_END         17'h17fff
`define BOOT_START      17'h18000
`define BOOT_END        17'h18fff
`define SECT_WORDS      17'h01000

`define REG_APP         2'h0
`define REG_TBL         2'h1
`define REG_BOOT        2'h2
`define REG_NONE        2'h3

`define LOCK_W          2
`define LOCK_OPEN       2'h3
`define LOCK_NOWRITE_B  0

`define SIG_WORDS       8
`define SIG_AW          3
`define SIG_CAL0_IDX    3'h0
`define SIG_CAL1_IDX    3'h1
`define SIG_DEVID_IDX   3'h2
`define SIG_LOT_IDX     3'h3
`define SIG_WAFER_IDX   3'h4
`define SIG_XY_IDX      3'h5
`define SIG_CAL2_IDX    3'h6
`define SIG_CAL3_IDX    3'h7

`endif

// ===== logic/sig_row_mem.v
// Purpose: factory signature row storage, registered read
// Assumes: contents fixed by parameters, read one word per cycle
// Notes:   identity words are arbitrary neutral values
`timescale 1ns/100ps
`include "flash_guard_defs.vh"

module sig_row_mem #(
    parameter [15:0] CAL0_VAL  = 16'h0000,
    parameter [15:0] CAL1_VAL  = 16'h0000,
    parameter [15:0] DEVID_VAL = 16'h1234, // arbitrary
    parameter [15:0] LOT_VAL   = 16'h0000,
    parameter [15:0] WAFER_VAL = 16'h0000,
    parameter [15:0] XY_VAL    = 16'h0000,
    parameter [15:0] CAL2_VAL  = 16'h0000,
    parameter [15:0] CAL3_VAL  = 16'h0000
) (
    input  wire                 sys_clk_in,
    input  wire [`SIG_AW-1:0]   rd_addr_in,
    output reg  [15:0]          rd_data_out
);

    reg [15:0] word;

    always @* begin
        case (rd_addr_in)
            `SIG_CAL0_IDX:  word = CAL0_VAL;
            `SIG_CAL1_IDX:  word = CAL1_VAL;
            `SIG_DEVID_IDX: word = DEVID_VAL;
            `SIG_LOT_IDX:   word = LOT_VAL;
            `SIG_WAFER_IDX: word = WAFER_VAL;
            `SIG_XY_IDX:    word = XY_VAL;
            `SIG_CAL2_IDX:  word = CAL2_VAL;
            default:        word = CAL3_VAL;
        endcase
    end

    always @(posedge sys_clk_in) begin
        rd_data_out <= word;
    end

endmodule // sig_row_mem

// ===== logic/flash_section_write_guard.v
// Purpose: decides whether a flash store may program, and loads calibration at reset
// Assumes: core presents one store request per pulse, same clock
// Notes:   lock settings come in as straps from fuse logic
`timescale 1ns/100ps
`include "flash_guard_defs.vh"

// How it works
// - stores start only when fetched from boot
// - app and boot regions locked independently
// - table region has its own lock
// - table size equals boot size
// - fixed word-address region decode
// - boot code may write app, table and boot regions, lock permitting
// - boot region lock from boot bits
// - calibration words CAL0 and CAL1 auto-loaded right after reset is released
// - signature row holds id and serial
module flash_section_write_guard #(
    parameter [15:0] CAL0_VAL  = 16'h0000,
    parameter [15:0] CAL1_VAL  = 16'h0000,
    parameter [15:0] DEVID_VAL = 16'h1234, // arbitrary
    parameter [15:0] LOT_VAL   = 16'h0000,
    parameter [15:0] WAFER_VAL = 16'h0000,
    parameter [15:0] XY_VAL    = 16'h0000,
    parameter [15:0] CAL2_VAL  = 16'h0000,
    parameter [15:0] CAL3_VAL  = 16'h0000
) (
    input  wire                 sys_clk_in,
    input  wire                 reset_in,
    input  wire                 store_req_in,
    input  wire [`ADDR_W-1:0]   store_pc_in,
    input  wire [`ADDR_W-1:0]   store_addr_in,
    input  wire [15:0]          store_data_in,
    input  wire [`LOCK_W-1:0]   lock_app_in,
    input  wire [`LOCK_W-1:0]   lock_tbl_in,
    input  wire [`LOCK_W-1:0]   lock_boot_in,
    input  wire                 sig_rd_in,
    input  wire [`SIG_AW-1:0]   sig_addr_in,
    output reg                  prog_go_out,
    output reg  [`ADDR_W-1:0]   prog_addr_out,
    output reg  [15:0]          prog_data_out,
    output reg                  store_done_out,
    output reg                  store_reject_out,
    output reg  [15:0]          cal_osc_out,
    output reg  [15:0]          cal_ana_out,
    output reg                  cal_valid_out,
    output reg  [15:0]          sig_data_out,
    output reg                  sig_valid_out
);

    // ==========================================================
    // region decode
    // ==========================================================
    function [1:0] region_of;
        input [`ADDR_W-1:0] a;
        begin
            if (a <= `APP_END)
                region_of = `REG_APP;
            else if (a <= `TBL_END)
                region_of = `REG_TBL;
            else if (a <= `BOOT_END)
                region_of = `REG_BOOT;
            else
                region_of = `REG_NONE;
        end
    endfunction

    wire [1:0] pc_region  = region_of(store_pc_in);
    wire [1:0] dst_region = region_of(store_addr_in);

    reg [`LOCK_W-1:0] dst_lock;
    always @* begin
        case (dst_region)
            `REG_APP:  dst_lock = lock_app_in;
            `REG_TBL:  dst_lock = lock_tbl_in;
            `REG_BOOT: dst_lock = lock_boot_in;
            default:   dst_lock = {`LOCK_W{1'b0}};
        endcase
    end

    wire from_boot  = (pc_region == `REG_BOOT);
    wire dst_ok     = (dst_region != `REG_NONE);
    wire lock_write = dst_lock[`LOCK_NOWRITE_B];
    wire allow      = from_boot & dst_ok & lock_write;

    // ==========================================================
    // store path
    // ==========================================================
    reg                 nxt_go;
    reg                 nxt_reject;
    reg [`ADDR_W-1:0]   nxt_addr;
    reg [15:0]          nxt_data;

    // rejected store still completes, but flash word and address stay put
    always @* begin
        nxt_go     = 1'b0;
        nxt_reject = 1'b0;
        nxt_addr   = prog_addr_out;
        nxt_data   = prog_data_out;
        if (store_req_in) begin
            if (allow) begin
                nxt_go   = 1'b1;
                nxt_addr = store_addr_in;
                nxt_data = store_data_in;
            end else begin
                nxt_reject = 1'b1;
            end
        end
    end

    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            prog_go_out      <= 1'b0;
            prog_addr_out    <= {`ADDR_W{1'b0}};
            prog_data_out    <= 16'h0000;
            store_done_out   <= 1'b0;
            store_reject_out <= 1'b0;
        end else begin
            prog_go_out      <= nxt_go;
            prog_addr_out    <= nxt_addr;
            prog_data_out    <= nxt_data;
            store_done_out   <= store_req_in;
            store_reject_out <= nxt_reject;
        end
    end

    // ==========================================================
    // signature row and reset-time calibration load
    // ==========================================================
    localparam [1:0] ST_CAL0 = 2'h0;
    localparam [1:0] ST_CAL1 = 2'h1;
    localparam [1:0] ST_FIN  = 2'h2;
    localparam [1:0] ST_RUN  = 2'h3;

    reg [1:0]          state_ff;
    reg [1:0]          nxt_state;
    reg [`SIG_AW-1:0]  mem_addr;
    reg                rd_pend_ff;
    wire [15:0]        mem_data;

    always @* begin
        case (state_ff)
            ST_CAL0: begin
                mem_addr  = `SIG_CAL0_IDX;
                nxt_state = ST_CAL1;
            end
            ST_CAL1: begin
                mem_addr  = `SIG_CAL1_IDX;
                nxt_state = ST_FIN;
            end
            ST_FIN: begin
                mem_addr  = sig_addr_in;
                nxt_state = ST_RUN;
            end
            default: begin
                mem_addr  = sig_addr_in;
                nxt_state = ST_RUN;
            end
        endcase
    end

    sig_row_mem #(
        .CAL0_VAL    (CAL0_VAL),
        .CAL1_VAL    (CAL1_VAL),
        .DEVID_VAL   (DEVID_VAL),
        .LOT_VAL     (LOT_VAL),
        .WAFER_VAL   (WAFER_VAL),
        .XY_VAL      (XY_VAL),
        .CAL2_VAL    (CAL2_VAL),
        .CAL3_VAL    (CAL3_VAL)
    ) u_sig (
        .sys_clk_in  (sys_clk_in),
        .rd_addr_in  (mem_addr),
        .rd_data_out (mem_data)
    );

    // ==========================================================
    // calibration capture
    // ==========================================================
    reg [15:0]         nxt_cal_osc;
    reg [15:0]         nxt_cal_ana;
    reg                nxt_cal_valid;

    // memory read data lags its address by one state
    always @* begin
        nxt_cal_osc   = cal_osc_out;
        nxt_cal_ana   = cal_ana_out;
        nxt_cal_valid = cal_valid_out;
        if (state_ff == ST_CAL1)
            nxt_cal_osc = mem_data;
        if (state_ff == ST_FIN) begin
            nxt_cal_ana   = mem_data;
            nxt_cal_valid = 1'b1;
        end
    end

    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            state_ff      <= ST_CAL0;
            rd_pend_ff    <= 1'b0;
            cal_osc_out   <= 16'h0000;
            cal_ana_out   <= 16'h0000;
            cal_valid_out <= 1'b0;
            sig_data_out  <= 16'h0000;
            sig_valid_out <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            rd_pend_ff    <= (state_ff == ST_RUN) & sig_rd_in;
            cal_osc_out   <= nxt_cal_osc;
            cal_ana_out   <= nxt_cal_ana;
            cal_valid_out <= nxt_cal_valid;
            sig_valid_out <= rd_pend_ff;
            if (rd_pend_ff)
                sig_data_out <= mem_data;
        end
    end

endmodule // flash_section_write_guard

// ===== sim/flash_guard_monitor.sv
// Purpose: store guard checker
// Assumes: one clock, sync reset
// Notes:   sees top ports only
`timescale 1ns/100ps
`include "flash_guard_defs.vh"
module flash_guard_monitor (
    input wire [0:0]         sys_clk_in,
    input wire [0:0]         reset_in,
    input wire [0:0]         store_req_in,
    input wire [`ADDR_W-1:0] store_pc_in,
    input wire [`ADDR_W-1:0] store_addr_in,
    input wire [`LOCK_W-1:0] lock_app_in,
    input wire [`LOCK_W-1:0] lock_tbl_in,
    input wire [`LOCK_W-1:0] lock_boot_in,
    input wire [0:0]         prog_go_out,
    input wire [`ADDR_W-1:0] prog_addr_out,
    input wire [0:0]         store_done_out,
    input wire [0:0]         store_reject_out
);
// ====
// region decode
wire ok = store_req_in && store_pc_in >= `BOOT_START && store_pc_in <= `BOOT_END;
wire tb = store_addr_in >= `TBL_START && store_addr_in <= `TBL_END;
wire bt = store_addr_in >= `BOOT_START && store_addr_in <= `BOOT_END;
default clocking @(posedge sys_clk_in); endclocking
default disable iff (reset_in);
pc_guard_a: assert property (store_req_in && !ok |=> store_reject_out && !prog_go_out)
    else $error("pc");
done_once_a: assert property (store_req_in |=> store_done_out)
    else $error("done");
done_cause_a: assert property (store_done_out |-> $past(store_req_in))
    else $error("cause");
app_lock_a: assert property (ok && store_addr_in <= `APP_END && !lock_app_in[0] |=> store_reject_out)
    else $error("app");
tbl_lock_a: assert property (ok && tb && !lock_tbl_in[0] |=> store_reject_out)
    else $error("tbl");
tbl_open_a: assert property (ok && tb && lock_tbl_in[0] |=> prog_go_out && !store_reject_out)
    else $error("tbl go");
boot_lock_a: assert property (ok && bt && !lock_boot_in[0] |=> store_reject_out)
    else $error("boot");
boot_reach_a: assert property (ok && bt && lock_boot_in[0] |=> prog_addr_out == $past(store_addr_in))
    else $error("reach");
endmodule // flash_guard_monitor
bind flash_section_write_guard flash_guard_monitor i_flash_guard_monitor (.*);

// ===== sim/core_store_model.sv
// Purpose: core issuing flash stores
// Assumes: bench asks one store a cycle
// Notes:   idle lines show inverted last value
`timescale 1ns/100ps
module core_store_model (
    input  wire        sys_clk_in,
    input  wire        go_in,
    input  wire [49:0] cmd_in,
    output reg         req_out = 1'b0,
    output reg  [49:0] cmd_out = 50'h0
);
// ====
// drive on falling edge
always @(negedge sys_clk_in) begin
    req_out <= go_in;
    cmd_out <= go_in ? cmd_in : ~cmd_out;
end
endmodule // core_store_model

// ===== sim/flash_section_write_guard_tb.sv
// Purpose: random and boundary stores, signature reads
// Assumes: expected results queued by the driver
// Notes:   locks change only between stores
`timescale 1ns/100ps
`include "flash_guard_defs.vh"
`define CHK(x, y) begin checks++; if ((x) !== (y)) begin miscompares++; \
    $display("mismatch %0t %h %h", $time, x, y); end end
module flash_section_write_guard_tb;
// ====
// signals
localparam [15:0] CAL0 = 16'h5a3c, CAL1 = 16'hc3a5, DEVID = 16'h7e21, LOT = 16'h0b17;
localparam [15:0] WAFER = 16'h0009, XY = 16'h2c13, CAL2 = 16'h96e1, CAL3 = 16'h4d72;
reg  [15:0] sig_val[0:7] = '{CAL0, CAL1, DEVID, LOT, WAFER, XY, CAL2, CAL3}; // id arbitrary
reg  sys_clk_in = 0, reset_in = 1, go = 0, sig_rd_in = 0, ok;
reg  [`LOCK_W-1:0] lock_app_in = 3, lock_tbl_in = 3, lock_boot_in = 3;
reg  [`SIG_AW-1:0] sig_addr_in = 0;
reg  [`ADDR_W-1:0] p, ta, edges[0:6] = '{17'h0, `APP_END, `TBL_START, `TBL_END,
    `BOOT_START, `BOOT_END, 17'h19000};
reg  [49:0] cmd = 0;
reg  [33:0] e, q[$];
reg  [15:0] sq[$];
wire store_req_in, prog_go_out, store_done_out, store_reject_out, cal_valid_out, sig_valid_out;
wire [`ADDR_W-1:0] store_pc_in, store_addr_in, prog_addr_out;
wire [15:0] store_data_in, prog_data_out, cal_osc_out, cal_ana_out, sig_data_out;
integer seed = 32'ha150, miscompares = 0, checks = 0, i, r;
flash_section_write_guard #(.CAL0_VAL(CAL0), .CAL1_VAL(CAL1), .DEVID_VAL(DEVID), .LOT_VAL(LOT),
    .WAFER_VAL(WAFER), .XY_VAL(XY), .CAL2_VAL(CAL2), .CAL3_VAL(CAL3))
    i_flash_section_write_guard (.*);
core_store_model i_core_store_model (.sys_clk_in(sys_clk_in), .go_in(go), .cmd_in(cmd),
    .req_out(store_req_in), .cmd_out({store_pc_in, store_addr_in, store_data_in}));
initial forever #25 sys_clk_in = ~sys_clk_in;
task give_verdict;
    begin
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
endtask
always @(negedge sys_clk_in) if (!reset_in) begin
    if (store_done_out === 1'b1) begin
        `CHK(q.size() > 0, 1'b1)
        e = q.pop_front();
        `CHK({prog_go_out, store_reject_out}, {e[33], !e[33]})
        if (e[33]) `CHK({prog_addr_out, prog_data_out}, e[32:0])
    end
    if (sig_valid_out === 1'b1) begin
        `CHK(sq.size() > 0, 1'b1)
        `CHK(sig_data_out, sq.pop_front())
    end
end
initial begin
    repeat (4) @(negedge sys_clk_in);
    `CHK({cal_valid_out, store_done_out, sig_valid_out}, 3'h0)
    reset_in <= 0;
    sig_rd_in <= 1;
    @(negedge sys_clk_in);
    sig_rd_in <= 0;
    for (i = 0; i < 20 && cal_valid_out !== 1'b1; i++) @(negedge sys_clk_in);
    if (i == 20) miscompares++;
    `CHK({cal_osc_out, cal_ana_out}, {CAL0, CAL1})
    for (i = 0; i < 400; i++) begin
        @(negedge sys_clk_in);
        if (i % 40 == 0) begin
            go <= 0;
            @(negedge sys_clk_in);
            r = $random(seed);
            {lock_app_in, lock_tbl_in, lock_boot_in} <= r[5:0];
            @(negedge sys_clk_in);
        end
        r = $random(seed);
        p = r[1:0] == 0 ? edges[r[4:2] % 7] : `BOOT_START + r[27:16];
        ta = r[5] ? edges[r[8:6] % 7] : r[31:15];
        ok = p >= `BOOT_START && p <= `BOOT_END && (ta <= `APP_END ? lock_app_in[0] :
            ta <= `TBL_END ? lock_tbl_in[0] : ta <= `BOOT_END && lock_boot_in[0]);
        go <= 1;
        cmd <= {p, ta, r[15:0]};
        q.push_back({ok, ta, r[15:0]});
    end
    @(negedge sys_clk_in);
    go <= 0;
    for (i = 0; i < `SIG_WORDS; i++) begin
        sig_rd_in <= 1;
        sig_addr_in <= i[`SIG_AW-1:0];
        sq.push_back(sig_val[i]);
        @(negedge sys_clk_in);
    end
    sig_rd_in <= 0;
    repeat (5) @(negedge sys_clk_in);
    `CHK(q.size() + sq.size(), 0)
    give_verdict;
end
endmodule // flash_section_write_guard_tb
